// ==== bench/pasl_board.sv ====
/*
  Board side of the five pins: pull to a strap rail through an LED.
  Assumes the device drives a pin only while its enable is high.
*/
`default_nettype none
module pasl_board (
  input wire logic [4:0] strap, // Rail of each pull
  input wire logic [4:0] oe, // Device drives pin
  input wire logic [4:0] drive, // Device drive value
  output logic [4:0] level, // Wire level
  output logic [4:0] lit // LED glows
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull sets the wire whenever the device lets go
  assign level = (oe & drive) | (~oe & strap);
  // Current flows only when driven against the rail
  assign lit = oe & (drive ^ strap);
endmodule
`default_nettype wire

// ==== bench/pasl_top_chk.sv ====
/*
  Checker of the strap and indicator pins.
  Assumes it is bound to pasl_top on one clock.
*/
`default_nettype none
module pasl_top_chk (
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset
  input wire pasl_pkg::pasl_status_s status, // Core status
  input wire logic addr0_activity_indicator_pin_out, // Drive
  input wire logic addr1_collision_indicator_pin_out, // Drive
  input wire logic addr2_link_indicator_pin_out, // Drive
  input wire logic addr3_tx_indicator_pin_out, // Drive
  input wire logic addr4_rx_indicator_pin_out, // Drive
  input wire logic addr2_link_indicator_pin_oe, // Enable
  input wire logic [4:0] phy_addr, // Address
  input wire logic addr_valid // Latched
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Strap latch and driver hand-over
  a_drive_after: assert property ($rose(rst_b) |=> addr_valid && addr2_link_indicator_pin_oe)
    else $error("drivers off after release");
  a_no_early: assert property (disable iff (1'b0) !rst_b |=> !addr2_link_indicator_pin_oe && !addr_valid)
    else $error("pin driven before latch");
  a_addr_steady: assert property (addr_valid |=> $stable(phy_addr) && addr_valid)
    else $error("address moved");
  // Indicators follow status one cycle later (collision two cycles, then held), inverted by strap
  a_link_shown: assert property (addr_valid |=>
    addr2_link_indicator_pin_out == ($past(status.link_up) ^ phy_addr[2])) else $error("link pin wrong");
  a_tx_shown: assert property (addr_valid |=>
    addr3_tx_indicator_pin_out == ($past(status.tx_active) ^ phy_addr[3])) else $error("tx pin wrong");
  a_rx_shown: assert property (addr_valid |=>
    addr4_rx_indicator_pin_out == ($past(status.rx_active) ^ phy_addr[4])) else $error("rx pin wrong");
  a_act_shown: assert property (addr_valid |=> addr0_activity_indicator_pin_out ==
    ($past(status.tx_active | status.rx_active) ^ phy_addr[0])) else $error("activity pin wrong");
  a_col_held: assert property (addr_valid && status.col_seen |->
    ##2 (addr1_collision_indicator_pin_out != phy_addr[1]) [*8]) else $error("collision not held");
  c_strap: cover property ($rose(addr_valid));
  c_col: cover property (addr_valid && status.col_seen);
  c_link: cover property (addr_valid && status.link_up);
endmodule
`default_nettype wire

// ==== bench/tb_pasl_top.sv ====
/*
  Testbench of pasl_top with the board model and checker.
  Assumes a short collision hold set by parameter.
*/
`default_nettype none
module tb_pasl_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HOLD = 20;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  pasl_pkg::pasl_status_s status = '0;
  logic [4:0] strap = 5'h00;
  wire logic [4:0] level, outs, oes, lit, phy_addr;
  wire logic addr_valid;
  int n_errors = 0;
  int num_checks = 0;
  pasl_board u_board (.strap(strap), .oe(oes), .drive(outs), .level(level), .lit(lit));
  pasl_top #(.COL_HOLD_CYCLES(HOLD)) u_dut (.clock(clock), .rst_b(rst_b), .status(status),
    .addr0_activity_indicator_pin_in(level[0]), .addr0_activity_indicator_pin_out(outs[0]),
    .addr0_activity_indicator_pin_oe(oes[0]), .addr1_collision_indicator_pin_in(level[1]),
    .addr1_collision_indicator_pin_out(outs[1]), .addr1_collision_indicator_pin_oe(oes[1]),
    .addr2_link_indicator_pin_in(level[2]), .addr2_link_indicator_pin_out(outs[2]),
    .addr2_link_indicator_pin_oe(oes[2]), .addr3_tx_indicator_pin_in(level[3]),
    .addr3_tx_indicator_pin_out(outs[3]), .addr3_tx_indicator_pin_oe(oes[3]),
    .addr4_rx_indicator_pin_in(level[4]), .addr4_rx_indicator_pin_out(outs[4]),
    .addr4_rx_indicator_pin_oe(oes[4]), .phy_addr(phy_addr), .addr_valid(addr_valid));
  // Clock
  initial forever #4 clock = ~clock;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reset with a strap pattern, then look at address, enables and idle pins
  task automatic do_reset(input logic [4:0] s);
    strap = s;
    rst_b = 1'b0;
    tick(5);
    rst_b = 1'b1;
    tick(2);
    chk(phy_addr, s);
    chk(oes, 5'h1F);
    chk(outs, s);
    chk(lit, 5'h00);
  endtask
  task automatic t_straps();
    logic [4:0] tab[4] = '{5'h00, 5'h1F, 5'h15, 5'h0A};
    foreach (tab[k]) do_reset(tab[k]);
    $display("test straps done");
  endtask
  // Every mix of link, transmit and receive
  task automatic t_indicators();
    for (int i = 0; i < 8; i++) begin
      status = pasl_pkg::pasl_status_s'({i[2:0], 1'b0});
      tick(2);
      chk(outs, strap ^ {i[0], i[1], i[2], 1'b0, i[1] | i[0]});
      chk(lit, {i[0], i[1], i[2], 1'b0, i[1] | i[0]});
    end
    chk(phy_addr, strap);
    status = '0;
    $display("test indicators done");
  endtask
  // One collision pulse is held for exactly the hold count; a second one mid-hold restarts it
  task automatic t_collision();
    status.col_seen = 1'b1;
    tick(1);
    status.col_seen = 1'b0;
    tick(1);
    chk(outs, strap ^ 5'h02);
    tick(HOLD - 1);
    chk(outs, strap ^ 5'h02);
    chk(lit, 5'h02);
    tick(1);
    chk(outs, strap);
    status.col_seen = 1'b1;
    tick(1);
    status.col_seen = 1'b0;
    tick(HOLD - 4);
    status.col_seen = 1'b1;
    tick(1);
    status.col_seen = 1'b0;
    tick(HOLD);
    chk(outs, strap ^ 5'h02);
    tick(1);
    chk(outs, strap);
    $display("test collision done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    t_straps();
    t_indicators();
    t_collision();
    end_of_test();
  end
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
endmodule
bind pasl_top pasl_top_chk u_chk (.clock(clock), .rst_b(rst_b), .status(status),
  .addr0_activity_indicator_pin_out(addr0_activity_indicator_pin_out),
  .addr1_collision_indicator_pin_out(addr1_collision_indicator_pin_out),
  .addr2_link_indicator_pin_out(addr2_link_indicator_pin_out),
  .addr3_tx_indicator_pin_out(addr3_tx_indicator_pin_out),
  .addr4_rx_indicator_pin_out(addr4_rx_indicator_pin_out),
  .addr2_link_indicator_pin_oe(addr2_link_indicator_pin_oe), .phy_addr(phy_addr), .addr_valid(addr_valid));
`default_nettype wire

// ==== hdl/pasl_pkg.sv ====
/*
  Shared constants and types of the strap and indicator pin block.
  Assumes one 125 MHz clock and five shared strap/indicator pins.
*/
`default_nettype none

package pasl_pkg;

  // Number of shared pins, one per management address bit
  localparam int unsigned ADDR_BITS = 5;

  // Address bit carried by each shared pin
  localparam int unsigned BIT_ACT = 0;
  localparam int unsigned BIT_COL = 1;
  localparam int unsigned BIT_LINK = 2;
  localparam int unsigned BIT_TX = 3;
  localparam int unsigned BIT_RX = 4;

  // Reset value of the latched address and of the pin drivers
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam logic [4:0] PIN_OUT_RESET = 5'h00;

  // Collision indicator hold time
  localparam int unsigned CLOCK_KHZ = 125000;
  localparam int unsigned COL_STRETCH_MS = 70;
  localparam int unsigned COL_STRETCH_CYCLES = COL_STRETCH_MS * CLOCK_KHZ;
  localparam int unsigned COL_CNT_W = 24;

  // Strap sequencing states
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_DRIVE = 2'b10
  } pasl_state_e;

  // Indicator status from the PHY core, all on the block clock
  typedef struct packed {
    logic link_up;
    logic tx_active;
    logic rx_active;
    logic col_seen;
  } pasl_status_s;

  // Input levels of the five shared pins
  typedef struct packed {
    logic [4:0] pin_in;
  } pasl_pins_s;

endpackage

`default_nettype wire

// ==== hdl/pasl_stretch.sv ====
/*
  Pulse stretcher for the collision indicator.
  Assumes the collision input is on the block clock; a count up to 16777215 (default 24-bit counter) is a parameter.
*/
`default_nettype none

module pasl_stretch #(
  parameter int unsigned CYCLES = pasl_pkg::COL_STRETCH_CYCLES,
  parameter int unsigned CNT_W = pasl_pkg::COL_CNT_W
) (
  input wire logic clock, // Block clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic trigger, // Collision seen this cycle
  output logic active // Held collision indication
);

  // Refuse a hold time the counter cannot hold
  if (CYCLES < 1 || CYCLES >= (64'd1 << CNT_W)) begin : g_bad_cycles
    $error("pasl_stretch: CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // Reload on every collision, otherwise count down to zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (trigger) begin
      nxt_cnt = LOAD;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end
  end

  // Counter register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign active = (cnt_ff != '0);

endmodule

`default_nettype wire

// ==== hdl/pasl_top.sv ====
/*
  Shared strap/indicator pins: sample five address straps at reset, then drive indicators.
  The latched address, the pin drive values and the pin enables all come from here;
  the collision hold count lives in a small stretcher module.
  Assumes each pin is pulled up or down through an LED, never floats, and that status
  inputs come from logic on the same clock. Pins are split into in, out and enable.
  Assumes the pins hold their strap levels for at least two clock edges before and
  one edge after reset is released, as the unreset synchronisers need that to fill.
*/
`default_nettype none

module pasl_top #(
  parameter int unsigned COL_HOLD_CYCLES = pasl_pkg::COL_STRETCH_CYCLES
) (
  input wire logic clock, // Block clock, 125 MHz
  input wire logic rst_b, // Power-on or hardware reset, active low
  input wire pasl_pkg::pasl_status_s status, // Link and activity state from the core
  input wire logic addr0_activity_indicator_pin_in, // Activity pin level
  output logic addr0_activity_indicator_pin_out, // Activity pin drive value
  output logic addr0_activity_indicator_pin_oe, // Activity pin driven
  input wire logic addr1_collision_indicator_pin_in, // Collision pin level
  output logic addr1_collision_indicator_pin_out, // Collision pin drive value
  output logic addr1_collision_indicator_pin_oe, // Collision pin driven
  input wire logic addr2_link_indicator_pin_in, // Link pin level
  output logic addr2_link_indicator_pin_out, // Link pin drive value
  output logic addr2_link_indicator_pin_oe, // Link pin driven
  input wire logic addr3_tx_indicator_pin_in, // Transmit pin level
  output logic addr3_tx_indicator_pin_out, // Transmit pin drive value
  output logic addr3_tx_indicator_pin_oe, // Transmit pin driven
  input wire logic addr4_rx_indicator_pin_in, // Receive pin level
  output logic addr4_rx_indicator_pin_out, // Receive pin drive value
  output logic addr4_rx_indicator_pin_oe, // Receive pin driven
  output logic [4:0] phy_addr, // Latched management address
  output logic addr_valid // Address latched, pins driving
);

  // One-hot mask of an address bit position
  function automatic logic [4:0] bit_mask(input int unsigned pos);
    return 5'h01 << pos;
  endfunction

  // Refuse a zero hold time, or one the collision counter cannot load
  if (COL_HOLD_CYCLES < 1 || COL_HOLD_CYCLES >= (64'h1 << pasl_pkg::COL_CNT_W)) begin : g_bad_hold
    $error("pasl_top: COL_HOLD_CYCLES out of range");
  end

  // Five pins are wired, one per address bit
  if (pasl_pkg::ADDR_BITS != 5) begin : g_bad_width
    $error("pasl_top: ADDR_BITS must be 5");
  end

  // Each address bit must be carried by exactly one pin
  if ((bit_mask(pasl_pkg::BIT_ACT) | bit_mask(pasl_pkg::BIT_COL) | bit_mask(pasl_pkg::BIT_LINK)
      | bit_mask(pasl_pkg::BIT_TX) | bit_mask(pasl_pkg::BIT_RX)) != 5'h1F) begin : g_bad_map
    $error("pasl_top: pin to address bit map is not one to one");
  end

  // Pin levels and their synchroniser stages
  pasl_pkg::pasl_pins_s pins;
  logic [4:0] sync1_ff;
  logic [4:0] nxt_sync1;
  logic [4:0] sync2_ff;
  logic [4:0] nxt_sync2;

  // Strap sequencing and the latched address
  pasl_pkg::pasl_state_e state_ff;
  pasl_pkg::pasl_state_e nxt_state;
  logic [4:0] addr_ff;
  logic [4:0] nxt_addr;

  // Pin drive values and indicator states
  logic [4:0] pin_out_ff;
  logic [4:0] nxt_pin_out;
  logic [4:0] ind;
  logic col_held;

  // Gather the pin levels in address bit order
  assign pins.pin_in[pasl_pkg::BIT_ACT] = addr0_activity_indicator_pin_in;
  assign pins.pin_in[pasl_pkg::BIT_COL] = addr1_collision_indicator_pin_in;
  assign pins.pin_in[pasl_pkg::BIT_LINK] = addr2_link_indicator_pin_in;
  assign pins.pin_in[pasl_pkg::BIT_TX] = addr3_tx_indicator_pin_in;
  assign pins.pin_in[pasl_pkg::BIT_RX] = addr4_rx_indicator_pin_in;

  // Next synchroniser stages; the first stage feeds only the second
  always_comb begin
    nxt_sync1 = pins.pin_in;
    nxt_sync2 = sync1_ff;
  end

  // Two-stage synchronisers, one per pin. They carry no reset on purpose:
  // while reset is held they keep tracking the pins, so the straps have
  // settled by the time the latch takes them.
  for (genvar i = 0; i < pasl_pkg::ADDR_BITS; i++) begin : g_sync
    always_ff @(posedge clock) begin
      sync1_ff[i] <= nxt_sync1[i];
      sync2_ff[i] <= nxt_sync2[i];
    end
  end

  // Latch straps in the first cycle after release, then drive for good.
  // Only rst_b or an illegal state code brings the machine back to STRAP, so nothing else can
  // resample the straps or turn the pins back into inputs.
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    unique case (state_ff)
      pasl_pkg::ST_STRAP: begin
        nxt_addr = sync2_ff;
        nxt_state = pasl_pkg::ST_DRIVE;
      end
      pasl_pkg::ST_DRIVE: begin
        nxt_state = pasl_pkg::ST_DRIVE;
      end
      default: begin
        // Illegal code: restart the strap sequence
        nxt_state = pasl_pkg::ST_STRAP;
      end
    endcase
  end

  // State and address registers; only the hardware reset returns here
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= pasl_pkg::ST_STRAP;
      addr_ff <= pasl_pkg::ADDR_RESET;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
    end
  end

  // Collision hold timer
  pasl_stretch #(
    .CYCLES(COL_HOLD_CYCLES),
    .CNT_W(pasl_pkg::COL_CNT_W)
  ) u_col_stretch (
    .clock(clock),
    .rst_b(rst_b),
    .trigger(status.col_seen),
    .active(col_held)
  );

  // Indicator states in address bit order
  always_comb begin
    ind = '0;
    ind[pasl_pkg::BIT_ACT] = status.tx_active | status.rx_active;
    ind[pasl_pkg::BIT_COL] = col_held;
    ind[pasl_pkg::BIT_LINK] = status.link_up;
    ind[pasl_pkg::BIT_TX] = status.tx_active;
    ind[pasl_pkg::BIT_RX] = status.rx_active;
  end

  // Asserted level is the inverse of the strap: strap XOR indicator.
  // The fresh address is used so the first driven value already matches
  // the strap and no LED flashes in the cycle the drivers turn on.
  always_comb begin
    nxt_pin_out = nxt_addr ^ ind;
  end

  // Pin drive registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_out_ff <= pasl_pkg::PIN_OUT_RESET;
    end else begin
      pin_out_ff <= nxt_pin_out;
    end
  end

  // Drivers on only once the straps are held; all five pins turn
  // around together in the cycle after the latch
  assign addr_valid = (state_ff == pasl_pkg::ST_DRIVE);
  assign addr0_activity_indicator_pin_oe = addr_valid;
  assign addr1_collision_indicator_pin_oe = addr_valid;
  assign addr2_link_indicator_pin_oe = addr_valid;
  assign addr3_tx_indicator_pin_oe = addr_valid;
  assign addr4_rx_indicator_pin_oe = addr_valid;

  // Drive values straight from the pin register
  assign addr0_activity_indicator_pin_out = pin_out_ff[pasl_pkg::BIT_ACT];
  assign addr1_collision_indicator_pin_out = pin_out_ff[pasl_pkg::BIT_COL];
  assign addr2_link_indicator_pin_out = pin_out_ff[pasl_pkg::BIT_LINK];
  assign addr3_tx_indicator_pin_out = pin_out_ff[pasl_pkg::BIT_TX];
  assign addr4_rx_indicator_pin_out = pin_out_ff[pasl_pkg::BIT_RX];

  // Address goes out straight from the address register
  assign phy_addr = addr_ff;

endmodule

`default_nettype wire
